//--- design/ctmf_ctrl.sv
`timescale 1ns/1ps
`include "ctmf_consts.svh"
module ctmf_ctrl
  import ctmf_pkg::*;
#(
  parameter int TXD_CYC = `CTMF_TXD_TO_US * `CTMF_CLK_MHZ,
  parameter int BUS_CYC = `CTMF_BUS_TO_US * `CTMF_CLK_MHZ,
  parameter int WAKE_CYC = `CTMF_WAKE_FILT_US * `CTMF_CLK_MHZ,
  parameter int RXREC_CYC = `CTMF_RXREC_US * `CTMF_CLK_MHZ
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire ctmf_bc_mode_type basis_chip_mode_i,
  input wire ctmf_can_mode_type mode_req_i,
  input wire logic mode_req_valid_i,
  input wire logic spi_cmd_i,
  input wire logic sleep_cmd_i,
  input wire ctmf_flag_type flag_clear_i,
  input wire logic tx_data_pin_i,
  input wire logic bus_dominant_i,
  input wire logic wake_rx_dominant_i,
  input wire logic rx_pin_i,
  input wire ctmf_fault_in_type fault_i,
  input wire ctmf_mask_type int_mask_i,
  output ctmf_can_mode_type can_mode_o,
  output logic bus_drive_dom_o,
  output logic bus_hiz_o,
  output logic wake_rx_sel_o,
  output logic rx_data_o,
  output logic split_en_o,
  output logic restart_req_o,
  output logic sleep_skip_o,
  output ctmf_flag_type flags_o,
  output ctmf_diag_type diag_o,
  output logic int_n_o
);
  localparam int CW = `CTMF_CNT_W;

  // table of CAN modes each basis-chip mode permits
  function automatic logic mode_ok(ctmf_bc_mode_type bc,
                                   ctmf_can_mode_type m);
    logic ok;
    ok = 1'b0;
    case (bc)
      BC_INIT: ok = (m == CTMF_OFF);
      BC_NORMAL: ok = 1'b1;
      BC_STOP, BC_SLEEP, BC_RESTART: begin
        ok = (m == CTMF_OFF) || (m == CTMF_WAKE);
      end
      BC_FAILSAFE: ok = (m == CTMF_WAKE);
      BC_FLASH: ok = (m == CTMF_NORM);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // mode taken when the basis chip leaves the current column
  function automatic ctmf_can_mode_type fallback(ctmf_bc_mode_type bc);
    ctmf_can_mode_type m;
    m = CTMF_WAKE;
    case (bc)
      BC_INIT: m = CTMF_OFF;
      BC_FLASH: m = CTMF_NORM;
      BC_NORMAL: m = CTMF_OFF;
      default: m = CTMF_WAKE;
    endcase
    return m;
  endfunction

  // saturating filter counter step
  function automatic logic [CW-1:0] cnt_step(logic run,
                                             logic [CW-1:0] c);
    logic [CW-1:0] n;
    n = '0;
    if (run && (c != '1)) begin
      n = c + 1'b1;
    end else if (run) begin
      n = c;
    end
    return n;
  endfunction

  ctmf_can_mode_type mode_r;
  ctmf_flag_type flags_r;
  ctmf_flag_type flag_set;
  ctmf_diag_type diag_nxt;
  logic [CW-1:0] tx_cnt_r;
  logic [CW-1:0] bus_cnt_r;
  logic [CW-1:0] wake_cnt_r;
  logic [CW-1:0] rr_cnt_r;
  logic wake_spent_r;
  logic wake_irq_r;
  logic rx_low_r;
  logic tx_to_r;
  logic txrx_inh_r;
  logic txrx_prev_r;
  logic rxrec_r;
  logic ot_r;
  logic tx_prev_r;
  logic active;
  logic tx_dom;
  logic tx_to_evt;
  logic clamp_evt;
  logic wake_evt;
  logic rr_cond;
  logic rr_evt;
  logic txrx_evt;
  logic local_evt;
  logic drv_ok;
  logic req_take;
  logic int_pend;

  // event decode; TX pin low means dominant
  assign active = (mode_r == CTMF_NORM) || (mode_r == CTMF_RO);
  assign tx_dom = !tx_data_pin_i;
  assign tx_to_evt = (mode_r == CTMF_NORM) && tx_dom && !tx_to_r &&
                     (tx_cnt_r == CW'(TXD_CYC - 1));
  assign clamp_evt = active && bus_dominant_i &&
                     (bus_cnt_r == CW'(BUS_CYC - 1));
  // off mode never counts, so wakes there are dropped
  assign wake_evt = (mode_r == CTMF_WAKE) && !wake_spent_r &&
                    wake_rx_dominant_i &&
                    (wake_cnt_r == CW'(WAKE_CYC - 1));
  assign rr_cond = active && bus_dominant_i && rx_pin_i;
  assign rr_evt = rr_cond && (rr_cnt_r == CW'(RXREC_CYC - 1));
  assign txrx_evt = fault_i.txrx_short && !txrx_prev_r;
  assign local_evt = tx_to_evt || txrx_evt || rr_evt;
  // a mode write riding on the sleep command is not honoured
  assign req_take = mode_req_valid_i && !sleep_cmd_i &&
                    mode_ok(basis_chip_mode_i, mode_req_i);

  // mode register: column fallback, then faults, then SPI
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      mode_r <= CTMF_OFF;
    end else if (!mode_ok(basis_chip_mode_i, mode_r)) begin
      mode_r <= fallback(basis_chip_mode_i);
    end else if ((clamp_evt || local_evt) && mode_r == CTMF_NORM &&
                 mode_ok(basis_chip_mode_i, CTMF_RO)) begin
      mode_r <= CTMF_RO;
    end else if (req_take) begin
      mode_r <= mode_req_i;
    end
  end

  // dominance filters; each restarts when its condition drops
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      tx_cnt_r <= '0;
      bus_cnt_r <= '0;
      wake_cnt_r <= '0;
      rr_cnt_r <= '0;
    end else begin
      tx_cnt_r <= cnt_step((mode_r == CTMF_NORM) && tx_dom && !tx_to_r,
                           tx_cnt_r);
      bus_cnt_r <= cnt_step(active && bus_dominant_i, bus_cnt_r);
      wake_cnt_r <= cnt_step((mode_r == CTMF_WAKE) && !wake_spent_r &&
                             wake_rx_dominant_i, wake_cnt_r);
      rr_cnt_r <= cnt_step(rr_cond, rr_cnt_r);
    end
  end

  // wake bookkeeping; rearm needs a visit to another mode
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wake_spent_r <= 1'b0;
      rx_low_r <= 1'b0;
      wake_irq_r <= 1'b0;
    end else begin
      if (wake_evt) begin
        wake_spent_r <= 1'b1;
        rx_low_r <= 1'b1;
      end else if (mode_r != CTMF_WAKE) begin
        wake_spent_r <= 1'b0;
        rx_low_r <= 1'b0;
      end
      // only stop and normal basis-chip modes raise the pin
      if (wake_evt && (basis_chip_mode_i == BC_STOP ||
                       basis_chip_mode_i == BC_NORMAL)) begin
        wake_irq_r <= 1'b1;
      end else if (flag_clear_i.wake) begin
        wake_irq_r <= 1'b0;
      end
    end
  end

  // restart request and sleep bypass, one-cycle pulses
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      restart_req_o <= 1'b0;
      sleep_skip_o <= 1'b0;
    end else begin
      sleep_skip_o <= sleep_cmd_i && (wake_evt || wake_spent_r);
      restart_req_o <= (sleep_cmd_i && (wake_evt || wake_spent_r)) ||
                       (wake_evt && (basis_chip_mode_i == BC_SLEEP ||
                        basis_chip_mode_i == BC_FAILSAFE ||
                        basis_chip_mode_i == BC_RESTART));
    end
  end

  // transmit lockouts; set wins over any clear
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      tx_to_r <= 1'b0;
      txrx_inh_r <= 1'b0;
      txrx_prev_r <= 1'b0;
      rxrec_r <= 1'b0;
      ot_r <= 1'b0;
      tx_prev_r <= 1'b1;
    end else begin
      txrx_prev_r <= fault_i.txrx_short;
      tx_prev_r <= tx_data_pin_i;
      // only an SPI return to normal mode frees the driver
      if (tx_to_evt) begin
        tx_to_r <= 1'b1;
      end else if (req_take && mode_req_i == CTMF_NORM) begin
        tx_to_r <= 1'b0;
      end
      if (txrx_evt) begin
        txrx_inh_r <= 1'b1;
      end else if (spi_cmd_i) begin
        txrx_inh_r <= 1'b0;
      end
      // stuck RX held off while the condition persists
      if (rr_evt) begin
        rxrec_r <= 1'b1;
      end else if (spi_cmd_i && !rr_cond) begin
        rxrec_r <= 1'b0;
      end
      // release on a recessive edge avoids a clipped bit
      if (fault_i.overtemp) begin
        ot_r <= 1'b1;
      end else if (!tx_prev_r && tx_data_pin_i) begin
        ot_r <= 1'b0;
      end
    end
  end

  // sticky failure flags, cleared bitwise by the controller
  always_comb begin
    flag_set = '0;
    flag_set.wake = wake_evt;
    flag_set.bus_clamp = clamp_evt;
    flag_set.txrx = txrx_evt;
    flag_set.bus_short = fault_i.bus_short;
    flag_set.tx_timeout = tx_to_evt;
    flag_set.rx_recessive = rr_evt;
    flag_set.overtemp = fault_i.overtemp;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      flags_r <= `CTMF_FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~flag_clear_i) | flag_set;
    end
  end

  // diagnostic code, highest-impact failure shown first
  always_comb begin
    diag_nxt = DIAG_NONE;
    if (flags_r.tx_timeout) begin
      diag_nxt = DIAG_TX_GND;
    end else if (flags_r.bus_clamp) begin
      diag_nxt = DIAG_CLAMP;
    end else if (flags_r.txrx) begin
      diag_nxt = DIAG_TXRX;
    end else if (flags_r.rx_recessive) begin
      diag_nxt = DIAG_RXREC;
    end else if (flags_r.overtemp) begin
      diag_nxt = DIAG_OT;
    end else if (flags_r.bus_short) begin
      diag_nxt = DIAG_BUS_SHORT;
    end
  end

  // unmasked pending sources pull the interrupt low
  assign int_pend = (wake_irq_r && !int_mask_i.wake) ||
                    (flags_r.bus_clamp && !int_mask_i.clamp) ||
                    (flags_r.txrx && !int_mask_i.txrx) ||
                    (flags_r.bus_short && !int_mask_i.bus);

  // driver needs normal mode, no lockout and enough supply
  assign drv_ok = (mode_r == CTMF_NORM) && !tx_to_r && !txrx_inh_r &&
                  !rxrec_r && !ot_r && !fault_i.supply_uv;

  // registered pin and status outputs
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      can_mode_o <= CTMF_OFF;
      bus_drive_dom_o <= 1'b0;
      bus_hiz_o <= 1'b1;
      wake_rx_sel_o <= 1'b0;
      rx_data_o <= 1'b1;
      split_en_o <= 1'b0;
      flags_o <= `CTMF_FLAGS_RST;
      diag_o <= DIAG_NONE;
      int_n_o <= 1'b1;
    end else begin
      can_mode_o <= mode_r;
      bus_drive_dom_o <= drv_ok && tx_dom;
      bus_hiz_o <= fault_i.supply_uv;
      wake_rx_sel_o <= (mode_r == CTMF_WAKE);
      split_en_o <= active && !fault_i.supply_uv;
      // wake holds RX low; active modes pass the receiver
      if (active) begin
        rx_data_o <= !bus_dominant_i;
      end else begin
        rx_data_o <= !rx_low_r;
      end
      flags_o <= flags_r;
      diag_o <= diag_nxt;
      int_n_o <= !int_pend;
    end
  end

  // checks on the controller
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  ro_no_drive_a: assert property (mode_r == CTMF_RO |=>
    !bus_drive_dom_o) else $error("driving in receive-only");
  uv_hiz_a: assert property (fault_i.supply_uv |=>
    bus_hiz_o && !split_en_o && !bus_drive_dom_o)
    else $error("bus not passive under undervoltage");
  mode_legal_a: assert property (1'b1 |=>
    mode_ok($past(basis_chip_mode_i), mode_r))
    else $error("CAN mode outside allowed column");
  wake_rx_a: assert property (wake_rx_sel_o ==
    (can_mode_o == CTMF_WAKE)) else $error("wrong receiver selected");
  skip_sleep_a: assert property (sleep_cmd_i && wake_evt |=>
    sleep_skip_o && restart_req_o) else $error("sleep not bypassed");
  sleep_wake_a: assert property (basis_chip_mode_i == BC_SLEEP &&
    wake_evt |=> restart_req_o) else $error("no restart on wake");
  txto_diag_a: assert property (flags_r.tx_timeout |=>
    diag_o == DIAG_TX_GND) else $error("timeout not coded TX-ground");
  clamp_ro_a: assert property (clamp_evt && mode_r == CTMF_NORM &&
    basis_chip_mode_i == BC_NORMAL && $stable(basis_chip_mode_i)
    |=> mode_r == CTMF_RO ##1 can_mode_o == CTMF_RO)
    else $error("clamp did not force receive-only");
  txto_stop_a: assert property (tx_to_evt |=> ##1
    !bus_drive_dom_o) else $error("driving after TX timeout");
  txrx_inh_a: assert property (txrx_evt |=> ##1
    !bus_drive_dom_o) else $error("driving after TX-RX short");
  ot_hold_a: assert property (ot_r |=> !bus_drive_dom_o)
    else $error("driving while overtemperature lockout");
  bus_int_a: assert property (flags_r.bus_short &&
    !int_mask_i.bus |=> !int_n_o) else $error("bus fault no interrupt");
  short_mode_a: assert property (fault_i.bus_short &&
    !mode_req_valid_i && !clamp_evt && !local_evt &&
    mode_ok(basis_chip_mode_i, mode_r) |=> $stable(mode_r))
    else $error("bus short changed mode");
  split_a: assert property (!fault_i.supply_uv |=>
    split_en_o == ($past(mode_r) == CTMF_NORM ||
    $past(mode_r) == CTMF_RO)) else $error("split state wrong");
  off_wake_a: assert property (mode_r == CTMF_OFF &&
    !flags_r.wake |=> !flags_r.wake) else $error("wake seen in off mode");

  wake_sleep_c: cover property (basis_chip_mode_i == BC_SLEEP &&
    wake_evt ##1 restart_req_o);
  clamp_c: cover property (clamp_evt ##1 mode_r == CTMF_RO);
  ot_release_c: cover property (ot_r ##1 !ot_r);
  txto_c: cover property (tx_to_evt ##2 diag_o == DIAG_TX_GND);
endmodule

//--- design/ctmf_consts.svh
`ifndef CTMF_CONSTS_SVH
`define CTMF_CONSTS_SVH
// Contract
// - receive-only: driver off, RX live, SPI entry
// - supply undervoltage: bus lines high impedance
// - CAN modes allowed per basis-chip mode
// - automatic mode moves stay within one column
// - leaving normal: switch to wake receiver
// - wake during sleep command: restart instead
// - sleep plus wake capable: wake gives restart
// - report failures; TX timeout as TX-ground
// - local or clamp failure: go receive-only
// - TX dominant too long: stop driving
// - bus clamped: flag, receive-only, interrupt
// - TX-RX short: report, interrupt, inhibit
// - overtemperature off, resume after TX edge
// - RX stuck recessive: transmitter off
// - bus line short sets bus-fault flag
// - bus line short keeps CAN mode
// - split active in normal and receive-only
// - stop-mode wake: flag, interrupt, RX low
// - rearm wake only after another mode
// - off mode ignores bus wake activity
`define CTMF_CLK_MHZ 40
`define CTMF_TXD_TO_US 1000
`define CTMF_BUS_TO_US 1000
`define CTMF_WAKE_FILT_US 1
`define CTMF_RXREC_US 2
`define CTMF_CNT_W 20
`define CTMF_FLAGS_RST 7'h00
`endif

//--- design/ctmf_pkg.sv
package ctmf_pkg;
  typedef enum logic [3:0] {
    CTMF_OFF = 4'h1,
    CTMF_WAKE = 4'h2,
    CTMF_NORM = 4'h4,
    CTMF_RO = 4'h8
  } ctmf_can_mode_type;
  typedef enum logic [6:0] {
    BC_INIT = 7'h01,
    BC_NORMAL = 7'h02,
    BC_STOP = 7'h04,
    BC_SLEEP = 7'h08,
    BC_RESTART = 7'h10,
    BC_FAILSAFE = 7'h20,
    BC_FLASH = 7'h40
  } ctmf_bc_mode_type;
  typedef enum logic [2:0] {
    DIAG_NONE = 3'h0,
    DIAG_TX_GND = 3'h1,
    DIAG_CLAMP = 3'h2,
    DIAG_TXRX = 3'h3,
    DIAG_RXREC = 3'h4,
    DIAG_OT = 3'h5,
    DIAG_BUS_SHORT = 3'h6
  } ctmf_diag_type;
  typedef struct packed {
    logic overtemp;
    logic supply_uv;
    logic txrx_short;
    logic bus_short;
  } ctmf_fault_in_type;
  typedef struct packed {
    logic wake;
    logic bus_clamp;
    logic txrx;
    logic bus_short;
    logic tx_timeout;
    logic rx_recessive;
    logic overtemp;
  } ctmf_flag_type;
  typedef struct packed {
    logic wake;
    logic clamp;
    logic txrx;
    logic bus;
  } ctmf_mask_type;
endpackage

//--- verification/ctmf_mcu_model.sv
`timescale 1ns/1ps
module ctmf_mcu_model
  import ctmf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rx_data_i,
  output ctmf_can_mode_type mode_req_o,
  output logic mode_req_valid_o,
  output logic spi_cmd_o,
  output logic sleep_cmd_o,
  output logic tx_data_pin_o,
  output logic rx_pin_o
);
  logic stuck = 1'b0;
  // idle: no command, tx recessive
  initial begin
    mode_req_o = CTMF_OFF;
    mode_req_valid_o = 1'b0;
    spi_cmd_o = 1'b0;
    sleep_cmd_o = 1'b0;
    tx_data_pin_o = 1'b1;
  end
  // rx readback; a short to the logic supply pins it high
  assign rx_pin_o = stuck ? 1'b1 : rx_data_i;
  // mode write frame, never the frame that orders sleep
  task automatic set_mode(ctmf_can_mode_type m);
    @(posedge sys_clk_i);
    mode_req_o <= m;
    mode_req_valid_o <= 1'b1;
    @(posedge sys_clk_i);
    mode_req_valid_o <= 1'b0;
  endtask
  // wake mode needs another mode first; armed before any sleep order
  task automatic arm_wake();
    set_mode(CTMF_OFF);
    set_mode(CTMF_WAKE);
  endtask
  task automatic spi();
    @(posedge sys_clk_i);
    spi_cmd_o <= 1'b1;
    @(posedge sys_clk_i);
    spi_cmd_o <= 1'b0;
  endtask
  // sleep order carries no mode change
  task automatic sleep();
    @(posedge sys_clk_i);
    sleep_cmd_o <= 1'b1;
    @(posedge sys_clk_i);
    sleep_cmd_o <= 1'b0;
  endtask
  task automatic tx(logic v);
    @(posedge sys_clk_i);
    tx_data_pin_o <= v;
  endtask
  // a short between the bus lines shows as a sent dominant bit that
  // never comes back on RX; the controller checks that itself
  task automatic echo(output logic seen);
    @(posedge sys_clk_i);
    tx_data_pin_o <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    seen = !rx_data_i;
    tx_data_pin_o <= 1'b1;
  endtask
  task automatic stick(logic v);
    @(posedge sys_clk_i);
    stuck <= v;
  endtask
endmodule

//--- verification/ctmf_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module ctmf_ctrl_test;
  import ctmf_pkg::*;
  // short counts keep the run brief
  localparam int TXD = 40;
  localparam int BUS = 24;
  localparam int WK = 4;
  localparam int RXR = 8;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  ctmf_bc_mode_type bc = BC_INIT;
  ctmf_can_mode_type mreq, can_mode;
  logic req_v, spi, slp, txd, rxp;
  ctmf_flag_type clr = '0;
  ctmf_flag_type flags;
  logic bus_dom = 1'b0;
  logic wk_dom = 1'b0;
  ctmf_fault_in_type flt = '0;
  ctmf_mask_type msk = '0;
  logic drv, hiz, wsel, rxd, split, rst_req, skip, int_n;
  ctmf_diag_type diag;
  int n_mismatch = 0;
  int compares = 0;
  int n_rst = 0;
  int n_skip = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  ctmf_ctrl #(.TXD_CYC(TXD), .BUS_CYC(BUS), .WAKE_CYC(WK),
    .RXREC_CYC(RXR)) i_ctmf_ctrl (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .basis_chip_mode_i(bc), .mode_req_i(mreq),
    .mode_req_valid_i(req_v), .spi_cmd_i(spi), .sleep_cmd_i(slp),
    .flag_clear_i(clr), .tx_data_pin_i(txd), .bus_dominant_i(bus_dom),
    .wake_rx_dominant_i(wk_dom), .rx_pin_i(rxp), .fault_i(flt),
    .int_mask_i(msk), .can_mode_o(can_mode), .bus_drive_dom_o(drv),
    .bus_hiz_o(hiz), .wake_rx_sel_o(wsel), .rx_data_o(rxd),
    .split_en_o(split), .restart_req_o(rst_req), .sleep_skip_o(skip),
    .flags_o(flags), .diag_o(diag), .int_n_o(int_n));
  ctmf_mcu_model i_ctmf_mcu_model (.sys_clk_i(sys_clk_i),
    .rx_data_i(rxd), .mode_req_o(mreq), .mode_req_valid_o(req_v),
    .spi_cmd_o(spi), .sleep_cmd_o(slp), .tx_data_pin_o(txd),
    .rx_pin_o(rxp));
  // one-cycle pulses counted at the edge after they appear
  always @(posedge sys_clk_i) begin
    if (rst_req === 1'b1) n_rst++;
    if (skip === 1'b1) n_skip++;
  end
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    #(25 * 20000);
    n_mismatch++;
    report_and_stop;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic setm(ctmf_can_mode_type m);
    i_ctmf_mcu_model.set_mode(m);
    cyc(3);
  endtask
  task automatic setbc(ctmf_bc_mode_type b);
    @(posedge sys_clk_i);
    bc <= b;
    cyc(4);
  endtask
  task automatic clear_all;
    @(posedge sys_clk_i);
    clr <= '1;
    @(posedge sys_clk_i);
    clr <= '0;
    cyc(3);
  endtask
  task automatic wake_pulse;
    @(posedge sys_clk_i);
    wk_dom <= 1'b1;
    cyc(WK + 2);
    @(posedge sys_clk_i);
    wk_dom <= 1'b0;
    cyc(3);
  endtask
  function automatic bit ok(ctmf_bc_mode_type b, ctmf_can_mode_type m);
    case (b)
      BC_INIT: return m == CTMF_OFF;
      BC_NORMAL: return 1'b1;
      BC_FAILSAFE: return m == CTMF_WAKE;
      BC_FLASH: return m == CTMF_NORM;
      default: return m inside {CTMF_OFF, CTMF_WAKE};
    endcase
  endfunction
  // every request in every basis mode; fallback on basis change
  task automatic t_table;
    ctmf_bc_mode_type bl[7] = '{BC_INIT, BC_NORMAL, BC_STOP, BC_SLEEP,
      BC_RESTART, BC_FAILSAFE, BC_FLASH};
    ctmf_can_mode_type ml[4] = '{CTMF_OFF, CTMF_WAKE, CTMF_NORM, CTMF_RO};
    ctmf_can_mode_type cur;
    cur = CTMF_OFF;
    foreach (bl[i]) begin
      setbc(bl[i]);
      if (!ok(bl[i], cur))
        cur = bl[i] == BC_INIT ? CTMF_OFF :
          bl[i] == BC_FLASH ? CTMF_NORM : CTMF_WAKE;
      `CHK(can_mode, cur)
      foreach (ml[j]) begin
        setm(ml[j]);
        if (ok(bl[i], ml[j])) cur = ml[j];
        `CHK(can_mode, cur)
        `CHK(split, cur inside {CTMF_NORM, CTMF_RO})
        if (cur == CTMF_WAKE && bl[i] inside {BC_STOP, BC_SLEEP})
          `CHK(wsel, 1'b1)
      end
    end
  endtask
  task automatic t_hiz;
    setbc(BC_NORMAL);
    setm(CTMF_NORM);
    i_ctmf_mcu_model.tx(1'b0);
    flt.supply_uv <= 1'b1;
    cyc(3);
    `CHK(hiz, 1'b1)
    `CHK(drv, 1'b0)
    `CHK(split, 1'b0)
    i_ctmf_mcu_model.tx(1'b1);
    // no undervoltage detector of its own: controller switches it off
    setm(CTMF_OFF);
    `CHK(can_mode, CTMF_OFF)
    @(posedge sys_clk_i);
    flt.supply_uv <= 1'b0;
    cyc(3);
    `CHK(hiz, 1'b0)
  endtask
  // receive-only: no drive, rx still follows the bus
  task automatic t_ro;
    logic seen;
    setm(CTMF_RO);
    i_ctmf_mcu_model.tx(1'b0);
    bus_dom <= 1'b1;
    cyc(3);
    `CHK(drv, 1'b0)
    `CHK(rxd, 1'b0)
    i_ctmf_mcu_model.tx(1'b1);
    bus_dom <= 1'b0;
    // a dominant bit sent in receive-only never reaches the bus
    i_ctmf_mcu_model.echo(seen);
    `CHK(seen, 1'b0)
  endtask
  task automatic t_txto;
    setm(CTMF_NORM);
    i_ctmf_mcu_model.tx(1'b0);
    cyc(3);
    `CHK(drv, 1'b1)
    cyc(TXD + 6);
    `CHK(flags.tx_timeout, 1'b1)
    `CHK(diag, DIAG_TX_GND)
    `CHK(drv, 1'b0)
    `CHK(can_mode, CTMF_RO)
    i_ctmf_mcu_model.tx(1'b1);
    setm(CTMF_NORM);
    i_ctmf_mcu_model.tx(1'b0);
    cyc(3);
    `CHK(drv, 1'b1)
    i_ctmf_mcu_model.tx(1'b1);
    clear_all;
  endtask
  // clamp unmasked, then masked
  task automatic t_clamp;
    for (int k = 0; k < 2; k++) begin
      setm(CTMF_NORM);
      @(posedge sys_clk_i);
      bus_dom <= 1'b1;
      msk.clamp <= k[0];
      cyc(BUS + 6);
      `CHK(flags.bus_clamp, 1'b1)
      `CHK(can_mode, CTMF_RO)
      `CHK(int_n, k[0])
      `CHK(diag, DIAG_CLAMP)
      @(posedge sys_clk_i);
      bus_dom <= 1'b0;
      clear_all;
      `CHK(int_n, 1'b1)
    end
  endtask
  // transmitter stays off until a later SPI command
  task automatic lock_chk;
    setm(CTMF_NORM);
    i_ctmf_mcu_model.tx(1'b0);
    cyc(3);
    `CHK(drv, 1'b0)
    i_ctmf_mcu_model.spi();
    cyc(3);
    `CHK(drv, 1'b1)
    i_ctmf_mcu_model.tx(1'b1);
    clear_all;
  endtask
  // short unmasked, then masked; controller cuts the supply after it
  task automatic t_txrx;
    for (int k = 0; k < 2; k++) begin
      setm(CTMF_NORM);
      @(posedge sys_clk_i);
      flt.txrx_short <= 1'b1;
      msk.txrx <= k[0];
      cyc(4);
      `CHK(flags.txrx, 1'b1)
      `CHK(int_n, k[0])
      `CHK(diag, DIAG_TXRX)
      `CHK(can_mode, CTMF_RO)
      @(posedge sys_clk_i);
      flt.txrx_short <= 1'b0;
      flt.supply_uv <= 1'b1;
      cyc(3);
      `CHK(hiz, 1'b1)
      `CHK(split, 1'b0)
      @(posedge sys_clk_i);
      flt.supply_uv <= 1'b0;
      lock_chk;
    end
  endtask
  task automatic t_rxstk;
    setm(CTMF_NORM);
    i_ctmf_mcu_model.stick(1'b1);
    bus_dom <= 1'b1;
    cyc(RXR + 4);
    `CHK(flags.rx_recessive, 1'b1)
    `CHK(diag, DIAG_RXREC)
    i_ctmf_mcu_model.stick(1'b0);
    bus_dom <= 1'b0;
    lock_chk;
  endtask
  // after cooling, tx must go recessive before driving again
  task automatic t_ot;
    setm(CTMF_NORM);
    i_ctmf_mcu_model.tx(1'b0);
    flt.overtemp <= 1'b1;
    cyc(3);
    `CHK(drv, 1'b0)
    `CHK(can_mode, CTMF_NORM)
    @(posedge sys_clk_i);
    flt.overtemp <= 1'b0;
    cyc(3);
    `CHK(drv, 1'b0)
    i_ctmf_mcu_model.tx(1'b1);
    i_ctmf_mcu_model.tx(1'b0);
    cyc(3);
    `CHK(drv, 1'b1)
    i_ctmf_mcu_model.tx(1'b1);
    clear_all;
  endtask
  // unmasked then masked; a clear while the short lasts loses to set
  task automatic t_bus;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk_i);
      flt.bus_short <= 1'b1;
      msk.bus <= k[0];
      cyc(4);
      `CHK(flags.bus_short, 1'b1)
      `CHK(int_n, k[0])
      `CHK(can_mode, CTMF_NORM)
      `CHK(diag, DIAG_BUS_SHORT)
      @(posedge sys_clk_i);
      clr.bus_short <= 1'b1;
      @(posedge sys_clk_i);
      clr.bus_short <= 1'b0;
      cyc(2);
      `CHK(flags.bus_short, 1'b1)
      @(posedge sys_clk_i);
      flt.bus_short <= 1'b0;
      clear_all;
      `CHK(flags.bus_short, 1'b0)
    end
  endtask
  // off ignores wake; stop wake; spent wake; rearm; sleep bypass
  task automatic t_wake;
    int k;
    setm(CTMF_OFF);
    setbc(BC_STOP);
    wake_pulse;
    `CHK(flags.wake, 1'b0)
    i_ctmf_mcu_model.arm_wake();
    cyc(3);
    `CHK(wsel, 1'b1)
    wake_pulse;
    `CHK(flags.wake, 1'b1)
    `CHK(int_n, 1'b0)
    `CHK(rxd, 1'b0)
    clear_all;
    setbc(BC_SLEEP);
    k = n_rst;
    wake_pulse;
    `CHK(n_rst, k)
    i_ctmf_mcu_model.arm_wake();
    cyc(3);
    wake_pulse;
    `CHK(n_rst, k + 1)
    i_ctmf_mcu_model.sleep();
    cyc(3);
    `CHK(n_skip, 1)
    `CHK(n_rst, k + 2)
    // sleep order lands in the very cycle the wake filter completes
    i_ctmf_mcu_model.arm_wake();
    cyc(3);
    @(posedge sys_clk_i);
    wk_dom <= 1'b1;
    repeat (WK - 2) @(posedge sys_clk_i);
    i_ctmf_mcu_model.sleep();
    cyc(3);
    `CHK(n_skip, 2)
    `CHK(n_rst, k + 3)
    // masked stop-mode wake: flag set, pin stays high
    @(posedge sys_clk_i);
    wk_dom <= 1'b0;
    msk.wake <= 1'b1;
    setbc(BC_STOP);
    clear_all;
    i_ctmf_mcu_model.arm_wake();
    cyc(3);
    wake_pulse;
    `CHK(flags.wake, 1'b1)
    `CHK(int_n, 1'b1)
    `CHK(rxd, 1'b0)
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    `CHK(can_mode, CTMF_OFF)
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_table;
    t_hiz;
    t_ro;
    t_txto;
    t_clamp;
    t_txrx;
    t_rxstk;
    t_ot;
    t_bus;
    t_wake;
    report_and_stop;
  end
endmodule
